//--- irq_enable_priority_regs.sv
// interrupt enable, priority and external request flag registers
//
// What this block does
// [R1] global enable bit 7 of main enable register blocks every source when 0
// [R2] main enable bits 6..0: adc, timer2, serial0, timer1, ext1, timer0, ext0
// [R3] second enable bits 3..0: ext2, base timer, pwm, serial1; 7..4 reserved
// [R4] pwm overflow flag raises a request only while its enable is set
// [R5] main priority bits 6..0 select high per source; bit 7 reserved
// [R6] second priority bits 3..0 select high for ext2..serial1; 7..4 reserved
// [R7] ext1 flag at timer control bit 3 set by event, cleared on acknowledge
// [R8] ext0 flag at timer control bit 1 set by event, cleared on acknowledge
// [R9] a source requests only with both global and own enable set
// [R10] high level preempts low service; equal or lower waits for return
// [R11] equal-level simultaneous requests serve the smallest query number first
// [R12] reserved bits ignore writes and read back as zero
`timescale 1ns/1ps
`default_nettype none
module irq_enable_priority_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // special function register access from the core
  input wire irq_pkg::sfr_req_t sfr_bus,
  output logic [7:0] sfr_rdata,
  // source events and flags
  input wire logic ext0_event,
  input wire logic ext1_event,
  input wire logic [irq_pkg::NUM_PERIPH-1:0] periph_flags,
  // request to the core
  output var irq_pkg::irq_out_t irq_out,
  output logic in_service_high,
  output logic in_service_low,
  // core handshake
  input wire logic irq_ack,
  input wire logic irq_reti
);
  import irq_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  logic [7:0] en_main_reg;
  logic [7:0] en_second_reg;
  logic [7:0] prio_main_reg;
  logic [7:0] prio_second_reg;
  logic ext0_request_flag_reg;
  logic ext1_request_flag_reg;
  logic in_svc_high_reg;
  logic in_svc_low_reg;
  logic [7:0] rdata_reg;
  irq_out_t irq_out_reg;

  logic ext0_flag_next;
  logic ext1_flag_next;
  logic in_svc_high_next;
  logic in_svc_low_next;
  logic [7:0] rdata_next;
  irq_out_t irq_out_next;

  // ****************************************************
  // address decode
  // ****************************************************
  logic hit_timer_ctrl;
  logic hit_en_main;
  logic hit_en_second;
  logic hit_prio_main;
  logic hit_prio_second;
  logic wr_timer_ctrl;

  // one wire per register
  assign hit_timer_ctrl = sfr_bus.addr == ADDR_TIMER_CTRL;
  assign hit_en_main = sfr_bus.addr == ADDR_EN_MAIN;
  assign hit_en_second = sfr_bus.addr == ADDR_EN_SECOND;
  assign hit_prio_main = sfr_bus.addr == ADDR_PRIO_MAIN;
  assign hit_prio_second = sfr_bus.addr == ADDR_PRIO_SECOND;
  assign wr_timer_ctrl = sfr_bus.wr && hit_timer_ctrl;

  // ****************************************************
  // external request flags
  // ****************************************************
  logic ack_ext0;
  logic ack_ext1;

  // the core takes the source shown on irq_out at the acknowledge
  assign ack_ext0 = irq_ack && irq_out_reg.req && irq_out_reg.num == SRC_EXT0;
  assign ack_ext1 = irq_ack && irq_out_reg.req && irq_out_reg.num == SRC_EXT1;

  // a fresh event wins over a write or acknowledge in the same cycle
  assign ext0_flag_next = ext0_event | (wr_timer_ctrl ? // R8
    sfr_bus.wdata[BIT_EXT0_FLAG] : (ext0_request_flag_reg & ~ack_ext0));
  assign ext1_flag_next = ext1_event | (wr_timer_ctrl ? // R7
    sfr_bus.wdata[BIT_EXT1_FLAG] : (ext1_request_flag_reg & ~ack_ext1));

  // ****************************************************
  // gating and priority split
  // ****************************************************
  logic global_irq_enable;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] prio_vec;
  logic [NUM_SRC-1:0] armed;
  logic [NUM_SRC-1:0] high_pend;
  logic [NUM_SRC-1:0] low_pend;

  // peripheral flags in query order with the two held flags placed in
  assign pend = {periph_flags[8:2], periph_flags[1], ext1_request_flag_reg,
                 periph_flags[0], ext0_request_flag_reg};
  assign global_irq_enable = en_main_reg[BIT_GLOBAL_EN];
  // enable bits line up with query numbers in both registers
  assign en_vec = {en_second_reg[SECOND_SRC_BITS-1:0], // R3
                   en_main_reg[MAIN_SRC_BITS-1:0]}; // R2
  assign prio_vec = {prio_second_reg[SECOND_SRC_BITS-1:0], // R6
                     prio_main_reg[MAIN_SRC_BITS-1:0]}; // R5
  // both global and own enable are needed; pwm overflow joins here
  assign armed = pend & en_vec & {NUM_SRC{global_irq_enable}}; // R1 R4 R9
  assign high_pend = armed & prio_vec;
  assign low_pend = armed & ~prio_vec;

  // ****************************************************
  // selection within each level
  // ****************************************************
  logic high_found;
  logic low_found;
  logic [3:0] high_num;
  logic [3:0] low_num;

  // lowest query number wins within a level
  irq_lowest_pick u_high_pick ( // R11
    .pend (high_pend),
    .found (high_found),
    .num (high_num)
  );

  irq_lowest_pick u_low_pick ( // R11
    .pend (low_pend),
    .found (low_found),
    .num (low_num)
  );

  // ****************************************************
  // nesting decision
  // ****************************************************
  logic high_ok;
  logic low_ok;

  // high preempts low service; same level waits for the return
  assign high_ok = high_found && !in_svc_high_reg; // R10
  assign low_ok = low_found && !in_svc_high_reg && !in_svc_low_reg; // R10
  // the acknowledge cycle drops the request so it is not taken twice
  assign irq_out_next.req = !irq_ack && (high_ok || low_ok);
  assign irq_out_next.high = high_ok;
  assign irq_out_next.num = high_ok ? high_num : low_num;

  // in-service levels: acknowledge marks, return clears the upper one
  always_comb begin
    in_svc_high_next = in_svc_high_reg;
    in_svc_low_next = in_svc_low_reg;
    if (irq_reti) begin
      if (in_svc_high_reg) begin
        in_svc_high_next = 1'b0;
      end else begin
        in_svc_low_next = 1'b0;
      end
    end
    if (irq_ack && irq_out_reg.req) begin
      if (irq_out_reg.high) begin
        in_svc_high_next = 1'b1; // R10
      end else begin
        in_svc_low_next = 1'b1; // R10
      end
    end
  end

  // ****************************************************
  // read data
  // ****************************************************
  logic [7:0] timer_ctrl_view;

  // only the two request flags live here; the rest read as zero
  assign timer_ctrl_view = {4'h0, ext1_request_flag_reg, 1'b0, // R12
                      ext0_request_flag_reg, 1'b0};

  // unmapped addresses and idle cycles return zero
  always_comb begin
    rdata_next = 8'h00;
    if (sfr_bus.rd) begin
      case (1'b1)
        hit_timer_ctrl: rdata_next = timer_ctrl_view;
        hit_en_main: rdata_next = en_main_reg;
        hit_en_second: rdata_next = en_second_reg;
        hit_prio_main: rdata_next = prio_main_reg;
        hit_prio_second: rdata_next = prio_second_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ****************************************************
  // registers
  // ****************************************************

  // software writable enables and priorities, reserved bits masked
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      en_main_reg <= RESET_BYTE;
      en_second_reg <= RESET_BYTE;
      prio_main_reg <= RESET_BYTE;
      prio_second_reg <= RESET_BYTE;
    end else if (sfr_bus.wr) begin
      if (hit_en_main) en_main_reg <= sfr_bus.wdata & MASK_EN_MAIN;
      if (hit_en_second) begin
        en_second_reg <= sfr_bus.wdata & MASK_EN_SECOND; // R12
      end
      if (hit_prio_main) begin
        prio_main_reg <= sfr_bus.wdata & MASK_PRIO_MAIN; // R12
      end
      if (hit_prio_second) begin
        prio_second_reg <= sfr_bus.wdata & MASK_PRIO_SECOND; // R12
      end
    end
  end

  // flags, nesting state and outputs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ext0_request_flag_reg <= 1'b0;
      ext1_request_flag_reg <= 1'b0;
      in_svc_high_reg <= 1'b0;
      in_svc_low_reg <= 1'b0;
      rdata_reg <= RESET_BYTE;
      irq_out_reg <= '0;
    end else begin
      ext0_request_flag_reg <= ext0_flag_next;
      ext1_request_flag_reg <= ext1_flag_next;
      in_svc_high_reg <= in_svc_high_next;
      in_svc_low_reg <= in_svc_low_next;
      rdata_reg <= rdata_next;
      irq_out_reg <= irq_out_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign irq_out = irq_out_reg;
  assign in_service_high = in_svc_high_reg;
  assign in_service_low = in_svc_low_reg;

  // ****************************************************
  // assertions
  // ****************************************************

  a_global_gate: assert property ( // R1
    @(posedge clk_sys) disable iff (!reset_n)
    !en_main_reg[BIT_GLOBAL_EN] |=> !irq_out_reg.req)
    else $error("request raised with global enable clear");

  a_main_readback: assert property ( // R2
    @(posedge clk_sys) disable iff (!reset_n)
    (sfr_bus.rd && hit_en_main) |=> sfr_rdata == $past(en_main_reg))
    else $error("main enable read mismatch");

  a_second_reserved: assert property ( // R3
    @(posedge clk_sys) disable iff (!reset_n)
    en_second_reg[7:4] == 4'h0)
    else $error("second enable reserved bits set");

  a_pwm_gate: assert property ( // R4
    @(posedge clk_sys) disable iff (!reset_n)
    (irq_out_reg.req && irq_out_reg.num == SRC_PWM)
      |-> $past(en_second_reg[BIT_PWM_EN]))
    else $error("pwm request without its enable");

  a_prio_reserved: assert property ( // R5
    @(posedge clk_sys) disable iff (!reset_n)
    !prio_main_reg[7])
    else $error("main priority reserved bit set");

  a_second_prio_read: assert property ( // R6
    @(posedge clk_sys) disable iff (!reset_n)
    (sfr_bus.rd && hit_prio_second) |=> sfr_rdata[7:4] == 4'h0
      && sfr_rdata[3:0] == $past(prio_second_reg[3:0]))
    else $error("second priority read mismatch");

  a_ext1_clear: assert property ( // R7
    @(posedge clk_sys) disable iff (!reset_n)
    (ack_ext1 && !ext1_event && !wr_timer_ctrl) |=> !ext1_request_flag_reg)
    else $error("ext1 flag not cleared on acknowledge");

  a_ext0_set: assert property ( // R8
    @(posedge clk_sys) disable iff (!reset_n)
    ext0_event |=> ext0_request_flag_reg ##1 1'b1)
    else $error("ext0 flag not set by event");

  a_source_gate: assert property ( // R9
    @(posedge clk_sys) disable iff (!reset_n)
    irq_out_reg.req |-> $past(armed) != '0)
    else $error("request without any armed source");

  a_high_block: assert property ( // R10
    @(posedge clk_sys) disable iff (!reset_n)
    in_svc_high_reg |=> !irq_out_reg.req)
    else $error("request raised during high service");

  a_high_first: assert property ( // R10
    @(posedge clk_sys) disable iff (!reset_n)
    (high_found && low_found && !in_svc_high_reg && !irq_ack)
      |=> irq_out_reg.req && irq_out_reg.high)
    else $error("low level chosen over high");

  a_query_order: assert property ( // R11
    @(posedge clk_sys) disable iff (!reset_n)
    (low_pend[SRC_EXT0] && !high_found && !in_svc_low_reg
      && !in_svc_high_reg && !irq_ack) |=> irq_out_reg.num == SRC_EXT0)
    else $error("lowest query number not served first");

  a_timer_ctrl_reserved: assert property ( // R12
    @(posedge clk_sys) disable iff (!reset_n)
    (sfr_bus.rd && hit_timer_ctrl) |=> (sfr_rdata & 8'hf5) == 8'h00)
    else $error("timer control reserved bits read nonzero");

endmodule : irq_enable_priority_regs
`default_nettype wire

//--- irq_pkg.sv
// constants and carrier types for the interrupt enable and priority bank
package irq_pkg;

  // ****************************************************
  // special function register addresses
  // ****************************************************
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADDR_EN_MAIN = 8'ha8;
  localparam logic [7:0] ADDR_EN_SECOND = 8'ha9;
  localparam logic [7:0] ADDR_PRIO_MAIN = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_SECOND = 8'hb9;

  // ****************************************************
  // values after reset and writable bit masks
  // ****************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MASK_EN_MAIN = 8'hff;
  localparam logic [7:0] MASK_EN_SECOND = 8'h0f;
  localparam logic [7:0] MASK_PRIO_MAIN = 8'h7f;
  localparam logic [7:0] MASK_PRIO_SECOND = 8'h0f;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_EXT1_FLAG = 3;
  localparam int BIT_EXT0_FLAG = 1;
  localparam int BIT_PWM_EN = 1;
  localparam int MAIN_SRC_BITS = 7;
  localparam int SECOND_SRC_BITS = 4;

  // ****************************************************
  // sources in query order, lowest number served first within a level
  // ****************************************************
  localparam int NUM_SRC = 11;
  localparam int NUM_PERIPH = 9;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TIMER0 = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_TIMER1 = 4'h3;
  localparam logic [3:0] SRC_SERIAL0 = 4'h4;
  localparam logic [3:0] SRC_TIMER2 = 4'h5;
  localparam logic [3:0] SRC_ADC = 4'h6;
  localparam logic [3:0] SRC_SERIAL1 = 4'h7;
  localparam logic [3:0] SRC_PWM = 4'h8;
  localparam logic [3:0] SRC_BASE_TIMER = 4'h9;
  localparam logic [3:0] SRC_EXT2 = 4'ha;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic req;
    logic high;
    logic [3:0] num;
  } irq_out_t;

endpackage : irq_pkg

//--- irq_lowest_pick.sv
// picks the lowest-numbered pending source of one priority level
`timescale 1ns/1ps
`default_nettype none
module irq_lowest_pick (
  // pending sources
  input wire logic [irq_pkg::NUM_SRC-1:0] pend,
  // winner
  output logic found,
  output logic [3:0] num
);
  import irq_pkg::*;

  logic [NUM_SRC-1:0] onehot;

  // a bit wins when no lower-numbered bit is pending
  assign onehot[0] = pend[0];
  genvar g;
  generate
    for (g = 1; g < NUM_SRC; g++) begin : g_win
      assign onehot[g] = pend[g] & ~(|pend[g-1:0]);
    end
  endgenerate

  assign found = |pend;

  // encode the single winning bit
  always_comb begin
    num = 4'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (onehot[i]) begin
        num = 4'(i);
      end
    end
  end

endmodule : irq_lowest_pick
`default_nettype wire

//--- core_model.sv
// core side model that takes interrupt requests and acknowledges them
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // request from the bank and bench control
  input wire irq_pkg::irq_out_t irq_out,
  input wire logic auto_ack,
  // handshake and record of taken requests
  output logic irq_ack,
  output logic [7:0] n_taken,
  output logic [3:0] last_num,
  output logic last_high
);
  import irq_pkg::*;
  // one ack pulse per shown request, raised only while req is high
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_ack <= 1'b0;
      n_taken <= 8'h00;
      last_num <= 4'h0;
      last_high <= 1'b0;
    end else begin
      irq_ack <= auto_ack & irq_out.req & ~irq_ack;
      if (irq_ack) begin
        n_taken <= n_taken + 8'h01;
        last_num <= irq_out.num;
        last_high <= irq_out.high;
      end
    end
  end
endmodule : core_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the interrupt enable and priority bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irq_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  sfr_req_t bus = '0;
  logic ext0_event = 1'b0;
  logic ext1_event = 1'b0;
  logic [NUM_PERIPH-1:0] periph_flags = '0;
  logic irq_reti = 1'b0;
  logic auto_ack = 1'b0;
  logic [7:0] sfr_rdata;
  irq_out_t irq_out;
  logic in_service_high;
  logic in_service_low;
  logic irq_ack;
  logic [7:0] n_taken;
  logic [3:0] last_num;
  logic last_high;
  int n_errors = 0;
  int comparisons = 0;

  // ****************************************************
  // design and core model
  // ****************************************************
  irq_enable_priority_regs i_irq_enable_priority_regs (
    .clk_sys(clk_sys), .reset_n(reset_n), .sfr_bus(bus),
    .sfr_rdata(sfr_rdata), .ext0_event(ext0_event),
    .ext1_event(ext1_event), .periph_flags(periph_flags),
    .irq_out(irq_out), .in_service_high(in_service_high),
    .in_service_low(in_service_low), .irq_ack(irq_ack),
    .irq_reti(irq_reti));
  core_model i_core_model (
    .clk_sys(clk_sys), .reset_n(reset_n), .irq_out(irq_out),
    .auto_ack(auto_ack), .irq_ack(irq_ack), .n_taken(n_taken),
    .last_num(last_num), .last_high(last_high));

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // ****************************************************
  // shared tasks
  // ****************************************************
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // step past n rising edges, then a small settle delay
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc
  // single byte write, strobe high for one edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    bus = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    cyc(1);
    bus.wr = 1'b0;
  endtask : sfr_wr
  // single byte read, data looked at in the cycle after the read edge
  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    bus = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    cyc(1);
    bus.rd = 1'b0;
    check(sfr_rdata, exp);
  endtask : sfr_chk
  // bounded waits on the request and on the core taking it
  task automatic wait_req();
    for (int i = 0; i < 8 && irq_out.req !== 1'b1; i++) cyc(1);
  endtask : wait_req
  task automatic take();
    logic [7:0] old;
    old = n_taken;
    auto_ack = 1'b1;
    for (int i = 0; i < 8 && n_taken === old; i++) cyc(1);
    auto_ack = 1'b0;
  endtask : take
  task automatic reti();
    cyc(1);
    irq_reti = 1'b1;
    cyc(1);
    irq_reti = 1'b0;
  endtask : reti

  // ****************************************************
  // scenarios
  // ****************************************************
  // reset values, writable masks, reserved bits and an unmapped address
  task automatic t_regs();
    logic [7:0] a [6] = '{ADDR_EN_MAIN, ADDR_EN_SECOND, ADDR_PRIO_MAIN,
      ADDR_PRIO_SECOND, ADDR_TIMER_CTRL, 8'h90};
    logic [7:0] m [6] = '{8'hff, 8'h0f, 8'h7f, 8'h0f, 8'h0a, 8'h00};
    for (int i = 0; i < 6; i++) begin
      sfr_chk(a[i], 8'h00);
      sfr_wr(a[i], 8'hff);
      sfr_chk(a[i], m[i]);
      sfr_wr(a[i], 8'h00);
    end
  endtask : t_regs
  // external flags: set by event, gated by global bit, cleared on ack
  task automatic t_ext(input logic sel);
    logic [7:0] en;
    en = sel ? 8'h04 : 8'h01;
    sfr_wr(ADDR_PRIO_MAIN, sel ? 8'h04 : 8'h00);
    sfr_wr(ADDR_EN_MAIN, en);
    cyc(1);
    ext0_event = !sel;
    ext1_event = sel;
    cyc(1);
    ext0_event = 1'b0;
    ext1_event = 1'b0;
    cyc(4);
    check(irq_out.req, 1'b0);
    sfr_chk(ADDR_TIMER_CTRL, sel ? 8'h08 : 8'h02);
    sfr_wr(ADDR_EN_MAIN, en | 8'h80);
    take();
    check(last_num, sel ? 8'h02 : 8'h00);
    check({last_high, in_service_high, in_service_low},
      sel ? 8'h06 : 8'h01);
    sfr_chk(ADDR_TIMER_CTRL, 8'h00);
    reti();
    cyc(1);
    check({in_service_high, in_service_low}, 8'h00);
    sfr_wr(ADDR_EN_MAIN, 8'h00);
    sfr_wr(ADDR_PRIO_MAIN, 8'h00);
  endtask : t_ext
  // each peripheral source alone: enable bit, priority bit, query number
  task automatic t_src();
    logic [15:0] m [9] = '{16'h0002, 16'h0008, 16'h0010, 16'h0020,
      16'h0040, 16'h0100, 16'h0200, 16'h0400, 16'h0800};
    logic [3:0] q [9] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
      4'h9, 4'ha};
    for (int i = 0; i < 9; i++) begin
      sfr_wr(ADDR_EN_MAIN, m[i][7:0] | 8'h80);
      sfr_wr(ADDR_EN_SECOND, m[i][15:8]);
      sfr_wr(ADDR_PRIO_MAIN, m[i][7:0]);
      sfr_wr(ADDR_PRIO_SECOND, m[i][15:8]);
      periph_flags = 9'(1) << i;
      wait_req();
      check({irq_out.req, irq_out.high, irq_out.num},
        {2'b11, q[i]});
      sfr_wr(ADDR_EN_MAIN, 8'h80);
      sfr_wr(ADDR_EN_SECOND, 8'h00);
      cyc(2);
      check(irq_out.req, 1'b0);
      periph_flags = '0;
    end
  endtask : t_src
  // query order, low service blocking low, high preempting, nesting
  task automatic t_nest();
    sfr_wr(ADDR_EN_MAIN, 8'hff);
    sfr_wr(ADDR_EN_SECOND, 8'h0f);
    sfr_wr(ADDR_PRIO_MAIN, 8'h02);
    // ext2 stays low here: the source sweep leaves its priority bit set
    sfr_wr(ADDR_PRIO_SECOND, 8'h00);
    periph_flags = 9'h1fe;
    wait_req();
    check({irq_out.high, irq_out.num}, 8'h03);
    take();
    cyc(3);
    check(irq_out.req, 1'b0);
    periph_flags[0] = 1'b1;
    wait_req();
    check({irq_out.req, irq_out.high, irq_out.num}, {2'b11, 4'h1});
    take();
    check({in_service_high, in_service_low}, 8'h03);
    cyc(3);
    check(irq_out.req, 1'b0);
    reti();
    wait_req();
    check({irq_out.req, irq_out.high, irq_out.num}, {2'b11, 4'h1});
    periph_flags = '0;
    reti();
    cyc(2);
    check({in_service_high, in_service_low, irq_out.req}, 8'h00);
  endtask : t_nest

  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    cyc(16);
    reset_n = 1'b1;
    t_regs();
    t_ext(1'b0);
    t_ext(1'b1);
    t_src();
    t_nest();
    complete_run();
  end
  // watchdog, well beyond the few hundred cycles the scenarios need
  initial begin
    #(25 * 4000);
    n_errors++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
